// ==== lcfg_regs.sv ====
// Logical device configuration register bank behind an APB slave
module lcfg_regs
    import lcfg_pkg::*;
(
    // Clock, standby reset, clock enable
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    // Further resets, synchronous levels
    input  wire logic        main_power_on_reset,
    input  wire logic        hard_reset,
    input  wire logic        soft_reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Peripheral bus
    input  wire logic        pbus_req,
    output logic             pbus_mode,
    output logic             pbus_strobe,
    output logic             pbus_wait,
    // Slow clock and wake-key logic
    output logic             slow_clock_absent,
    output logic             key_wake_enable,
    // Interrupt routing
    input  wire logic        ext_irq_input_a,
    input  wire logic        ext_irq_input_b,
    input  wire logic        ext_irq_input_c,
    input  wire logic        ext_irq_input_d,
    input  wire logic        sys_mgmt_irq_req,
    output logic      [15:0] serirq_slots,
    // Host I/O decode of the management bus controller
    input  wire logic [15:0] io_addr,
    input  wire logic        io_cycle,
    output logic             smbus_hit,
    output logic             smbus_base_valid
);

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [7:0]  xbus_sel;
        logic [7:0]  slow_clk;
        logic [7:0]  route_first;
        logic [7:0]  route_second;
        logic [3:0]  smb_hi;
        logic [4:0]  smb_lo;
        logic        key_en;
        logic [15:0] slots;
        logic        hit;
        logic        base_valid;
    } lcfg_regs_state_type;

    lcfg_regs_state_type s_reg;
    lcfg_regs_state_type s_next;

    lcfg_strobe_if sif ();

    logic [15:0] slot_calc;
    logic [15:0] base_addr;
    logic        base_ok;
    logic        acc_phase;
    logic        wr_done;
    logic        lock_clear;

    // ==========================================================
    // Address decoding, shared by read and write
    function automatic lcfg_reg_sel_type decode(input logic [11:0] a);
        lcfg_reg_sel_type r;
        logic [1:0] bank;
        logic [7:0] idx;
        bank = a[BANK_LSB +: 2];
        idx  = a[BANK_LSB-1:2];
        r    = SEL_NONE;
        if (a[1:0] != 2'h0) begin
            r = SEL_NONE;
        end else if (bank == BANK_XBUS && idx == IDX_XBUS_SEL) begin
            r = SEL_XBUS;
        end else if (bank == BANK_RUNTIME && idx == IDX_SLOW_CLK) begin
            r = SEL_SLOW;
        end else if (bank == BANK_RUNTIME && idx == IDX_ROUTE_FIRST) begin
            r = SEL_ROUTE_FIRST;
        end else if (bank == BANK_RUNTIME && idx == IDX_ROUTE_SECOND) begin
            r = SEL_ROUTE_SECOND;
        end else if (bank == BANK_SMB && idx == IDX_SMB_BASE_HI) begin
            r = SEL_SMB_HI;
        end else if (bank == BANK_SMB && idx == IDX_SMB_BASE_LO) begin
            r = SEL_SMB_LO;
        end
        return r;
    endfunction

    // One routing nibble: zero leaves the input off every slot
    function automatic logic routes_to(input logic [3:0] nib,
                                       input logic [3:0] slot);
        return (nib != 4'h0) && (nib == slot);
    endfunction

    // ==========================================================
    // Serial interrupt slot mapping
    assign slot_calc[0] = 1'b0;
    for (genvar n = 1; n < SLOT_COUNT; n++) begin : g_slot
        localparam logic [3:0] SLOT = 4'(n);
        assign slot_calc[n] =
            (routes_to(s_reg.route_first[3:0], SLOT) && ext_irq_input_a) ||
            (routes_to(s_reg.route_first[7:4], SLOT) && ext_irq_input_b) ||
            (routes_to(s_reg.route_second[3:0], SLOT) && ext_irq_input_c) ||
            (routes_to(s_reg.route_second[7:4], SLOT) && ext_irq_input_d) ||
            (SLOT == SLOT_SHARED_SMI && sys_mgmt_irq_req);
    end

    // Slot 2 is an OR of the management request and any routed input;
    // software must silence the management source before reusing it.

    // ==========================================================
    // Management bus controller base address
    assign base_addr = {4'h0, s_reg.smb_hi, s_reg.smb_lo, 3'h0};
    assign base_ok   = (base_addr >= SMB_BASE_MIN) &&
                       (base_addr <= SMB_BASE_MAX);

    // ==========================================================
    // APB handshake: one wait cycle, so prdata comes from a flop
    assign acc_phase  = psel && penable;
    assign wr_done    = acc_phase && s_reg.pready && pwrite;
    assign lock_clear = main_power_on_reset || hard_reset;

    // ==========================================================
    // Next state
    always_comb begin
        lcfg_reg_sel_type sel;
        logic [7:0] rd;
        sel    = decode(paddr);
        rd     = 8'h00;
        s_next = s_reg;

        s_next.pready  = acc_phase && !s_reg.pready;
        s_next.pslverr = acc_phase && !s_reg.pready && sel == SEL_NONE;

        case (sel)
            SEL_XBUS:         rd = s_reg.xbus_sel;
            SEL_SLOW:         rd = s_reg.slow_clk;
            SEL_ROUTE_FIRST:  rd = s_reg.route_first;
            SEL_ROUTE_SECOND: rd = s_reg.route_second;
            SEL_SMB_HI:       rd = {4'h0, s_reg.smb_hi};
            SEL_SMB_LO:       rd = {s_reg.smb_lo, 3'h0};
            default:          rd = 8'h00;
        endcase
        s_next.prdata = (acc_phase && !s_reg.pready && !pwrite) ?
                        {24'h0, rd} : 32'h0;

        if (wr_done) begin
            case (sel)
                SEL_XBUS: begin
                    if (!s_reg.xbus_sel[XBUS_PROTECT_BIT]) begin
                        s_next.xbus_sel = pwdata[7:0] & XBUS_WMASK;
                    end
                end
                SEL_SLOW: begin
                    s_next.slow_clk = pwdata[7:0] & SLOW_WMASK;
                end
                SEL_ROUTE_FIRST: begin
                    s_next.route_first = pwdata[7:0];
                end
                SEL_ROUTE_SECOND: begin
                    s_next.route_second = pwdata[7:0];
                end
                SEL_SMB_HI: begin
                    s_next.smb_hi = pwdata[3:0];
                end
                SEL_SMB_LO: begin
                    s_next.smb_lo = pwdata[7:3];
                end
                default: begin
                end
            endcase
        end

        // Later resets; the standby reset is the asynchronous one
        if (lock_clear) begin
            s_next.xbus_sel[XBUS_PROTECT_BIT] = 1'b0;
        end
        if (lock_clear || soft_reset) begin
            s_next.smb_hi = 4'h0;
            s_next.smb_lo = 5'h00;
        end

        s_next.key_en = !s_next.slow_clk[KEY_WAKE_DIS_BIT];
        s_next.slots  = slot_calc;
        s_next.base_valid = base_ok;
        // A base out of range never matches, so such cycles are ignored
        s_next.hit = io_cycle && base_ok &&
                     io_addr[15:3] == base_addr[15:3];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0,
                       xbus_sel: CFG_RESET, slow_clk: CFG_RESET,
                       route_first: CFG_RESET, route_second: CFG_RESET,
                       smb_hi: 4'h0, smb_lo: 5'h00, key_en: 1'b1,
                       slots: 16'h0000, hit: 1'b0, base_valid: 1'b0};
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // ==========================================================
    // Strobe timer
    assign sif.req       = pbus_req && !sif.strobe;
    assign sif.width_sel = s_reg.xbus_sel[XBUS_WIDTH_LSB +: 2];

    lcfg_strobe_timer u_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .ce      (ce),
        .sif     (sif.timer)
    );

    // ==========================================================
    // Outputs
    assign prdata            = s_reg.prdata;
    assign pready            = s_reg.pready;
    assign pslverr           = s_reg.pslverr;
    assign pbus_mode         = s_reg.xbus_sel[XBUS_MODE_BIT];
    assign pbus_strobe       = sif.strobe;
    assign pbus_wait         = sif.wait_sync;
    assign slow_clock_absent = s_reg.slow_clk[SLOW_ABSENT_BIT];
    assign key_wake_enable   = s_reg.key_en;
    assign serirq_slots      = s_reg.slots;
    assign smbus_hit         = s_reg.hit;
    assign smbus_base_valid  = s_reg.base_valid;

    // ==========================================================
    // Checks
    property p_lock_write;
        @(posedge clk) disable iff (!reset_n)
        ce && wr_done && decode(paddr) == SEL_XBUS &&
        s_reg.xbus_sel[XBUS_PROTECT_BIT] && !lock_clear
            |=> $stable(s_reg.xbus_sel);
    endproperty
    a_lock_write: assert property (p_lock_write)
        else $error("locked selection register changed");

    property p_lock_sticky;
        @(posedge clk) disable iff (!reset_n)
        s_reg.xbus_sel[XBUS_PROTECT_BIT] && !lock_clear
            |=> s_reg.xbus_sel[XBUS_PROTECT_BIT];
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lock bit cleared without reset");

    property p_mode_write;
        @(posedge clk) disable iff (!reset_n)
        ce && wr_done && decode(paddr) == SEL_XBUS &&
        !s_reg.xbus_sel[XBUS_PROTECT_BIT]
            |=> pbus_mode == $past(pwdata[0]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("bus mode not taken from bit 0");

    property p_key_gate;
        @(posedge clk) disable iff (!reset_n)
        ce && wr_done && decode(paddr) == SEL_SLOW
            |=> key_wake_enable == !$past(pwdata[1]);
    endproperty
    a_key_gate: assert property (p_key_gate)
        else $error("wake-key enable does not follow bit 1");

    property p_route_a;
        @(posedge clk) disable iff (!reset_n)
        ce && ext_irq_input_a && s_reg.route_first[3:0] == 4'h5
            |=> serirq_slots[5];
    endproperty
    a_route_a: assert property (p_route_a)
        else $error("input A not on slot 5");

    property p_route_d14;
        @(posedge clk) disable iff (!reset_n)
        ce && ext_irq_input_d && s_reg.route_second[7:4] == 4'he
            |=> serirq_slots[14];
    endproperty
    a_route_d14: assert property (p_route_d14)
        else $error("input D not on slot 14");

    property p_slot_zero;
        @(posedge clk) disable iff (!reset_n)
        !serirq_slots[0];
    endproperty
    a_slot_zero: assert property (p_slot_zero)
        else $error("slot 0 driven");

    property p_bad_base;
        @(posedge clk) disable iff (!reset_n)
        ce && !base_ok |=> !smbus_hit;
    endproperty
    a_bad_base: assert property (p_bad_base)
        else $error("hit on out-of-range base");

    property p_high_bits;
        @(posedge clk) disable iff (!reset_n)
        ce && io_cycle && io_addr[15:12] != 4'h0 |=> !smbus_hit;
    endproperty
    a_high_bits: assert property (p_high_bits)
        else $error("hit with upper address bits set");

    property p_low_zero;
        @(posedge clk) disable iff (!reset_n)
        pready && !pwrite && decode(paddr) == SEL_SMB_LO
            |-> prdata[2:0] == 3'h0;
    endproperty
    a_low_zero: assert property (p_low_zero)
        else $error("fixed base bits read nonzero");

endmodule

// ==== lcfg_pkg.sv ====
// Constants and types shared by the configuration register bank
package lcfg_pkg;

    // ==========================================================
    // Register indexes; byte address = bank base + 4 * index
    localparam logic [7:0]  IDX_SMB_BASE_HI  = 8'h60;
    localparam logic [7:0]  IDX_SMB_BASE_LO  = 8'h61;
    localparam logic [7:0]  IDX_XBUS_SEL     = 8'hf0;
    localparam logic [7:0]  IDX_SLOW_CLK     = 8'hf0;
    localparam logic [7:0]  IDX_ROUTE_FIRST  = 8'hf4;
    localparam logic [7:0]  IDX_ROUTE_SECOND = 8'hf5;

    // ==========================================================
    // Logical device banks, selected by paddr[11:10]
    localparam int          BANK_LSB     = 10;
    localparam logic [1:0]  BANK_XBUS    = 2'h0;
    localparam logic [1:0]  BANK_RUNTIME = 2'h1;
    localparam logic [1:0]  BANK_SMB     = 2'h2;

    // ==========================================================
    // Field positions, write masks and reset values
    localparam int          XBUS_MODE_BIT    = 0;
    localparam int          XBUS_WIDTH_LSB   = 2;
    localparam int          XBUS_PROTECT_BIT = 7;
    localparam logic [7:0]  XBUS_WMASK       = 8'h8d;
    localparam int          SLOW_ABSENT_BIT  = 0;
    localparam int          KEY_WAKE_DIS_BIT = 1;
    localparam logic [7:0]  SLOW_WMASK       = 8'h03;
    localparam logic [7:0]  CFG_RESET        = 8'h00;
    localparam logic [15:0] SMB_BASE_MIN     = 16'h0100;
    localparam logic [15:0] SMB_BASE_MAX     = 16'h0ff8;
    localparam int          SLOT_COUNT       = 16;
    localparam logic [3:0]  SLOT_SHARED_SMI  = 4'h2;

    // ==========================================================
    // Strobe widths; least times round up to whole cycles
    localparam int CLK_PERIOD_NS = 100;
    localparam int STROBE_NS_0   = 180;
    localparam int STROBE_NS_1   = 300;
    localparam int STROBE_NS_2   = 420;
    localparam int STROBE_NS_3   = 540;
    localparam logic [2:0] STROBE_CYC_0 =
        3'((STROBE_NS_0 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] STROBE_CYC_1 =
        3'((STROBE_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] STROBE_CYC_2 =
        3'((STROBE_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] STROBE_CYC_3 =
        3'((STROBE_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ==========================================================
    // Enumerations
    typedef enum logic [2:0] {
        SEL_NONE, SEL_SMB_HI, SEL_SMB_LO, SEL_XBUS,
        SEL_SLOW, SEL_ROUTE_FIRST, SEL_ROUTE_SECOND
    } lcfg_reg_sel_type;

    typedef enum logic {ST_IDLE, ST_STROBE} lcfg_strobe_state_type;

endpackage

// ==== lcfg_strobe_if.sv ====
// Link between the register bank and the peripheral strobe timer
interface lcfg_strobe_if;
    logic       req;
    logic [1:0] width_sel;
    logic       strobe;
    logic       wait_sync;

    modport ctrl  (output req, output width_sel,
                   input strobe, input wait_sync);
    modport timer (input req, input width_sel,
                   output strobe, output wait_sync);
endinterface

// ==== lcfg_strobe_timer.sv ====
// Peripheral bus read/write strobe timer with host wait insertion
module lcfg_strobe_timer
    import lcfg_pkg::*;
(
    // Clock, reset, enable
    input wire logic      clk,
    input wire logic      reset_n,
    input wire logic      ce,
    // Link to the register bank
    lcfg_strobe_if.timer  sif
);

    typedef struct packed {
        lcfg_strobe_state_type state;
        logic [2:0]            count;
        logic [1:0]            sel;
        logic                  strobe;
        logic                  wait_sync;
    } lcfg_timer_state_type;

    lcfg_timer_state_type s_reg;
    lcfg_timer_state_type s_next;

    function automatic logic [2:0] width_cycles(input logic [1:0] w);
        logic [2:0] c;
        c = STROBE_CYC_0;
        if (w == 2'h3) begin
            c = STROBE_CYC_3;
        end else if (w == 2'h2) begin
            c = STROBE_CYC_2;
        end else if (w == 2'h1) begin
            c = STROBE_CYC_1;
        end
        return c;
    endfunction

    // ==========================================================
    // Strobe sequencing
    always_comb begin
        s_next = s_reg;
        case (s_reg.state)
            ST_IDLE: begin
                if (sif.req) begin
                    s_next.state     = ST_STROBE;
                    s_next.sel       = sif.width_sel;
                    s_next.count     = width_cycles(sif.width_sel);
                    s_next.strobe    = 1'b1;
                    s_next.wait_sync = 1'b1;
                end
            end
            ST_STROBE: begin
                s_next.count = s_reg.count - 3'h1;
                if (s_reg.count == 3'h1) begin
                    s_next.state     = ST_IDLE;
                    s_next.strobe    = 1'b0;
                    s_next.wait_sync = 1'b0;
                end
            end
            default: begin
                s_next.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_reg <= '{ST_IDLE, 3'h0, 2'h0, 1'b0, 1'b0};
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign sif.strobe    = s_reg.strobe;
    assign sif.wait_sync = s_reg.wait_sync;

    // ==========================================================
    // Checks
    property p_width_540;
        @(posedge clk) disable iff (!reset_n || !ce)
        $rose(s_reg.strobe) && s_reg.sel == 2'h3
            |-> s_reg.strobe [*6] ##1 !s_reg.strobe;
    endproperty
    a_width_540: assert property (p_width_540)
        else $error("strobe not six cycles at widest setting");

    property p_width_180;
        @(posedge clk) disable iff (!reset_n || !ce)
        $rose(s_reg.strobe) && s_reg.sel == 2'h0
            |-> s_reg.strobe [*2] ##1 !s_reg.strobe;
    endproperty
    a_width_180: assert property (p_width_180)
        else $error("strobe not two cycles at default setting");

    property p_wait_cover;
        @(posedge clk) disable iff (!reset_n)
        s_reg.strobe |-> s_reg.wait_sync;
    endproperty
    a_wait_cover: assert property (p_wait_cover)
        else $error("host cycle released before strobe end");

endmodule

// ==== lcfg_pbus_partner.sv ====
// Peripheral bus requester model that times each strobe
module lcfg_pbus_partner (
    // Clock
    input  wire logic clk,
    // Strobe request and answer
    output logic      pbus_req,
    input  wire logic pbus_strobe,
    input  wire logic pbus_wait
);
    timeunit 1ns;
    timeprecision 1ns;

    initial pbus_req = 1'b0;

    // ==========================================================
    // Request
    // One-cycle pulse, so a held level cannot start a second strobe;
    // twelve edges outlast the widest strobe before the next request
    task automatic run(output int n, output bit bad);
        n = 0;
        bad = 1'b0;
        @(posedge clk);
        pbus_req <= 1'b1;
        @(posedge clk);
        pbus_req <= 1'b0;
        repeat (12) begin
            @(posedge clk);
            if (pbus_wait !== pbus_strobe) bad = 1'b1;
            if (pbus_strobe === 1'b1) n++;
        end
    endtask
endmodule

// ==== logical_device_config_registers_test.sv ====
// Self-checking bench for the configuration register bank
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module logical_device_config_registers_test;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, reset_n, ce, main_por, hard_rst, soft_rst;
    logic        psel, penable, pwrite, pready, pslverr, err;
    logic        pbus_req, pbus_mode, pbus_strobe, pbus_wait;
    logic        slow_absent, key_wake_en, base_valid, smb_hit;
    logic        io_cycle, smi_req;
    logic [3:0]  irq_in;
    logic [7:0]  v;
    logic [11:0] paddr;
    logic [15:0] slots, io_addr;
    logic [31:0] pwdata, prdata, rd;
    int          num_errors, cmp_count, cycles, i, j, n;
    int          ns_tab[4] = '{180, 300, 420, 540};
    bit          bad;

    lcfg_regs lcfg_regs_i (.clk(clk), .reset_n(reset_n), .ce(ce),
        .main_power_on_reset(main_por), .hard_reset(hard_rst),
        .soft_reset(soft_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pbus_req(pbus_req),
        .pbus_mode(pbus_mode), .pbus_strobe(pbus_strobe),
        .pbus_wait(pbus_wait), .slow_clock_absent(slow_absent),
        .key_wake_enable(key_wake_en), .ext_irq_input_a(irq_in[0]),
        .ext_irq_input_b(irq_in[1]), .ext_irq_input_c(irq_in[2]),
        .ext_irq_input_d(irq_in[3]), .sys_mgmt_irq_req(smi_req),
        .serirq_slots(slots), .io_addr(io_addr), .io_cycle(io_cycle),
        .smbus_hit(smb_hit), .smbus_base_valid(base_valid));
    lcfg_pbus_partner lcfg_pbus_partner_i (.clk(clk), .pbus_req(pbus_req),
        .pbus_strobe(pbus_strobe), .pbus_wait(pbus_wait));

    // ==========================================================
    // Clock and hang guard
    initial clk = 1'b0;
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end

    // ==========================================================
    // Access tasks
    // Values are sampled right after the edge, so they are the ones the
    // edge itself saw
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // If pready never comes, only the bench timeout ends this wait
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(rd, {24'h0, e})
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask

    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ==========================================================
    // Tests
    initial begin
        {psel, penable, pwrite, main_por, hard_rst, soft_rst} = '0;
        {io_cycle, smi_req, irq_in, io_addr, paddr, pwdata} = '0;
        ce = 1'b1;
        reset_n = 1'b0;
        tick(10);
        reset_n <= 1'b1;
        `CHK(key_wake_en, 1'b1)
        chk_rd(12'h3c0, 8'h00);
        chk_rd(12'h7c0, 8'h00);
        chk_rd(12'h7d0, 8'h00);
        chk_rd(12'h980, 8'h00);
        apb(1'b0, 12'h004, 8'h00);
        `CHK(err, 1'b1)
        for (i = 0; i < 4; i++) begin
            apb(1'b1, 12'h3c0, 8'(i * 4 + 1));
            chk_rd(12'h3c0, 8'(i * 4 + 1));
            `CHK(pbus_mode, 1'b1)
            lcfg_pbus_partner_i.run(n, bad);
            `CHK(n, (ns_tab[i] + 99) / 100)
            `CHK(bad, 1'b0)
        end
        // Lock survives soft reset; hard then main power reset clear it
        for (i = 0; i < 2; i++) begin
            apb(1'b1, 12'h3c0, 8'h80);
            apb(1'b1, 12'h3c0, 8'h01);
            `CHK(err, 1'b0)
            chk_rd(12'h3c0, 8'h80);
            soft_rst <= 1'b1;
            tick(1);
            soft_rst <= 1'b0;
            chk_rd(12'h3c0, 8'h80);
            if (i == 0) hard_rst <= 1'b1;
            else main_por <= 1'b1;
            tick(1);
            hard_rst <= 1'b0;
            main_por <= 1'b0;
            chk_rd(12'h3c0, 8'h00);
        end
        `CHK(pbus_mode, 1'b0)
        apb(1'b1, 12'h7c0, 8'hff);
        chk_rd(12'h7c0, 8'h03);
        `CHK({slow_absent, key_wake_en}, 2'b10)
        chk_rd(12'h3c0, 8'h00);
        apb(1'b1, 12'h7c0, 8'h00);
        tick(2);
        `CHK({slow_absent, key_wake_en}, 2'b01)
        // Slots freeze while the enable is low, then slot 2 follows
        ce <= 1'b0;
        smi_req <= 1'b1;
        tick(3);
        `CHK(slots, 16'h0000)
        ce <= 1'b1;
        tick(3);
        `CHK(slots, 16'h0004)
        smi_req <= 1'b0;
        tick(3);
        for (j = 0; j < 4; j++) begin
            for (n = 0; n < 16; n++) begin
                v = j[0] ? {n[3:0], 4'h0} : {4'h0, n[3:0]};
                apb(1'b1, (j < 2) ? 12'h7d0 : 12'h7d4, v);
                irq_in <= 4'(1 << j);
                tick(3);
                `CHK(slots, 16'((1 << n) & 16'hfffe))
                irq_in <= 4'h0;
            end
        end
        apb(1'b1, 12'h980, 8'hff);
        apb(1'b1, 12'h984, 8'hff);
        chk_rd(12'h980, 8'h0f);
        chk_rd(12'h984, 8'hf8);
        io_addr <= 16'h0ff8;
        io_cycle <= 1'b1;
        tick(3);
        `CHK({base_valid, smb_hit}, 2'b11)
        io_addr <= 16'h1ff8;
        tick(3);
        `CHK(smb_hit, 1'b0)
        apb(1'b1, 12'h980, 8'h00);
        apb(1'b1, 12'h984, 8'h08);
        io_addr <= 16'h0008;
        tick(3);
        `CHK({base_valid, smb_hit}, 2'b00)
        apb(1'b1, 12'h980, 8'h01);
        apb(1'b1, 12'h984, 8'h00);
        io_addr <= 16'h0100;
        tick(3);
        `CHK({base_valid, smb_hit}, 2'b11)
        soft_rst <= 1'b1;
        tick(1);
        soft_rst <= 1'b0;
        chk_rd(12'h980, 8'h00);
        conclude();
    end
endmodule
